/* File: rtl/nfs_status_protect.sv */
// Functional notes
// [RL1] read-status returns the status byte; write-status loads it from frame data.
// [RL2] disable bit set with write-protect low freezes nonvolatile bits; write-status ignored.
// [RL3] only raising write-protect or a reset leaves the frozen state; no command releases it.
// [RL4] bit 7 is the nonvolatile write-disable bit, default 0 meaning writes allowed.
// [RL5] bit 5 anchors the protected region: 0 top (default), 1 bottom.
// [RL6] block-protect bits at 6 and 4:2 bar program and erase in their region.
// [RL7] bit 1 is the write-enable latch; modifying commands need it set.
// [RL8] the write-enable latch comes up cleared after every reset.
// [RL9] bit 0 reads 1 while a write, program or erase cycle runs, else 0.
// [RL10] die erase runs only when every block-protect bit is 0.
// [RL11] status bit 0 is always the inverse of flag status bit 7.
// [RL12] byte addresses up to the last map to 64KB sectors in ascending order.
// [RL13] flag status bit 7 reads 0 while busy and 1 when ready.
// [RL14] the write-enable latch clears when a modifying operation ends or is refused.
// [RL15] new nonvolatile values take effect only when the write cycle ends.
`timescale 1ns/100ps
module nfs_status_protect
  import nfs_pkg::*;
#(
  parameter logic [31:0] T_WRSR_CYC = NFS_T_WRSR_CYC,
  parameter logic [31:0] T_PROG_CYC = NFS_T_PROG_CYC,
  parameter logic [31:0] T_SUB_CYC  = NFS_T_SUB_CYC,
  parameter logic [31:0] T_SECT_CYC = NFS_T_SECT_CYC,
  parameter logic [31:0] T_DIE_CYC  = NFS_T_DIE_CYC
)
(
  // core clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // serial link pins
  input  wire logic                  link_clk,
  input  wire logic                  link_sel_b,
  input  wire logic                  link_din,
  output logic                       link_dout,
  output logic                       link_dout_oe,
  input  wire logic                  wp_b,
  // array side
  output logic                       array_op_start,
  output logic [2:0]                 array_op,
  output logic [NFS_ADDR_W-1:0]      array_addr,
  // status view
  output logic [7:0]                 status_byte,
  output logic [7:0]                 flag_byte,
  output logic                       busy
);

  logic                      clk_s;
  logic                      sel_b_s;
  logic                      din_s;
  logic                      wp_b_s;
  logic                      clk_d_reg;
  logic                      sel_d_reg;
  logic                      link_rise;
  logic                      link_fall;
  logic                      sel_fall;
  logic                      sel_rise;
  nfs_state_e                state_reg;
  logic [7:0]                cmd_reg;
  logic [31:0]               addr_reg;
  logic [7:0]                data_reg;
  logic [5:0]                bit_cnt_reg;
  logic                      armed_reg;
  logic                      rd_flag_reg;
  logic [2:0]                rd_idx_reg;
  logic [7:0]                rd_byte;
  logic [7:0]                nv_reg;
  logic [7:0]                pend_nv_reg;
  logic                      wel_reg;
  logic [31:0]               busy_cnt_reg;
  nfs_op_e                   op_reg;
  nfs_op_e                   req_op;
  logic [31:0]               dur;
  logic [3:0]                bp;
  logic                      frozen;
  logic                      blocked;
  logic                      exec;
  logic                      req_ok;
  logic                      start;
  logic                      reject;
  logic                      finish;
  logic [NFS_SECTOR_W-1:0]   sector;

  // pins cross into the core clock before anything looks at them
  nfs_sync #(.W(4), .RST_VAL(4'h5)) u_sync
  (
    .clock (clock),
    .rst_b (rst_b),
    .din   ({link_clk, link_sel_b, link_din, wp_b}),
    .dout  ({clk_s, sel_b_s, din_s, wp_b_s})
  );

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
    end
    else
    begin
      clk_d_reg <= clk_s;
      sel_d_reg <= sel_b_s;
    end
  end

  assign link_rise = clk_s & ~clk_d_reg & ~sel_b_s;
  assign link_fall = ~clk_s & clk_d_reg & ~sel_b_s;
  assign sel_fall  = ~sel_b_s & sel_d_reg;
  assign sel_rise  = sel_b_s & ~sel_d_reg;

  // frame decoder: commands run when select rises, so a cut-short frame does nothing
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg   <= NFS_ST_IDLE;
      cmd_reg     <= 8'h00;
      addr_reg    <= 32'h0000_0000;
      data_reg    <= 8'h00;
      bit_cnt_reg <= 6'h00;
      armed_reg   <= 1'b0;
      rd_flag_reg <= 1'b0;
    end
    else if (sel_fall)
    begin
      state_reg   <= NFS_ST_CMD;
      bit_cnt_reg <= 6'h00;
      armed_reg   <= 1'b0;
    end
    else if (sel_b_s)
      state_reg <= NFS_ST_IDLE;
    else if (link_rise)
    begin
      case (state_reg)
        NFS_ST_CMD:
        begin
          cmd_reg     <= {cmd_reg[6:0], din_s};
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          if (bit_cnt_reg == NFS_LAST_BYTE_BIT)
          begin
            bit_cnt_reg <= 6'h00;
            case ({cmd_reg[6:0], din_s})
              NFS_CMD_RDSR, NFS_CMD_RDFS:
              begin
                state_reg   <= NFS_ST_READ; // [RL1]
                rd_flag_reg <= ({cmd_reg[6:0], din_s} == NFS_CMD_RDFS);
              end
              NFS_CMD_WRSR:
                state_reg <= NFS_ST_DATA;
              NFS_CMD_PROG, NFS_CMD_SE, NFS_CMD_SS32, NFS_CMD_SS4:
                state_reg <= NFS_ST_ADDR;
              NFS_CMD_WREN, NFS_CMD_WRDI, NFS_CMD_DIE:
              begin
                state_reg <= NFS_ST_SKIP;
                armed_reg <= 1'b1;
              end
              default:
                state_reg <= NFS_ST_SKIP;
            endcase
          end
        end
        NFS_ST_ADDR:
        begin
          addr_reg    <= {addr_reg[30:0], din_s};
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          if (bit_cnt_reg == NFS_LAST_ADDR_BIT)
          begin
            state_reg <= NFS_ST_SKIP;
            armed_reg <= 1'b1;
          end
        end
        NFS_ST_DATA:
        begin
          data_reg    <= {data_reg[6:0], din_s}; // [RL1]
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          if (bit_cnt_reg == NFS_LAST_BYTE_BIT)
          begin
            state_reg <= NFS_ST_SKIP;
            armed_reg <= 1'b1;
          end
        end
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // read-out repeats the live byte for as long as the frame lasts
  assign rd_byte = rd_flag_reg ? flag_byte : status_byte;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_dout  <= 1'b0;
      rd_idx_reg <= 3'h0;
    end
    else if (sel_fall)
      rd_idx_reg <= 3'h0;
    else if (state_reg == NFS_ST_READ && link_fall)
    begin
      link_dout  <= rd_byte[3'h7 - rd_idx_reg]; // [RL1]
      rd_idx_reg <= rd_idx_reg + 3'h1;
    end
  end

  assign link_dout_oe = (state_reg == NFS_ST_READ);

  assign bp     = {nv_reg[NFS_SR_BP3_BIT], nv_reg[NFS_SR_BP_HI:NFS_SR_BP_LO]};
  assign frozen = nv_reg[NFS_SR_SRWD_BIT] & ~wp_b_s; // [RL2] [RL3] [RL4]
  assign sector = addr_reg[NFS_SECTOR_SHIFT +: NFS_SECTOR_W]; // [RL12]
  assign busy   = (busy_cnt_reg != 32'h0000_0000);
  assign finish = (busy_cnt_reg == 32'h0000_0001);

  nfs_region_guard u_guard
  (
    .bp         (bp),
    .top_bottom (nv_reg[NFS_SR_TB_BIT]), // [RL5]
    .sector     (sector),
    .die        (req_op == NFS_OP_DIE),
    .blocked    (blocked)
  );

  // nothing but reads is obeyed while a cycle runs
  always_comb
  begin
    exec = sel_rise & armed_reg & ~busy;
    case (cmd_reg)
      NFS_CMD_WRSR: req_op = NFS_OP_WRSR;
      NFS_CMD_PROG: req_op = NFS_OP_PROG;
      NFS_CMD_SE:   req_op = NFS_OP_SE;
      NFS_CMD_SS32: req_op = NFS_OP_SS32;
      NFS_CMD_SS4:  req_op = NFS_OP_SS4;
      NFS_CMD_DIE:  req_op = NFS_OP_DIE;
      default:      req_op = NFS_OP_NONE;
    endcase
    case (req_op)
      NFS_OP_WRSR: dur = T_WRSR_CYC;
      NFS_OP_PROG: dur = T_PROG_CYC;
      NFS_OP_SE:   dur = T_SECT_CYC;
      NFS_OP_DIE:  dur = T_DIE_CYC;
      default:     dur = T_SUB_CYC;
    endcase
    req_ok = wel_reg & ~blocked & ~((req_op == NFS_OP_WRSR) & frozen); // [RL2] [RL6] [RL7]
    start  = exec & (req_op != NFS_OP_NONE) & req_ok;
    reject = exec & (req_op != NFS_OP_NONE) & ~req_ok;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      wel_reg <= 1'b0; // [RL8]
    else if (finish || reject || (exec && cmd_reg == NFS_CMD_WRDI))
      wel_reg <= 1'b0; // [RL14]
    else if (exec && cmd_reg == NFS_CMD_WREN)
      wel_reg <= 1'b1; // [RL7]
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_cnt_reg <= 32'h0000_0000;
      op_reg       <= NFS_OP_NONE;
      pend_nv_reg  <= NFS_SR_NV_RESET;
    end
    else if (start)
    begin
      busy_cnt_reg <= dur; // [RL9]
      op_reg       <= req_op;
      pend_nv_reg  <= data_reg & NFS_SR_NV_MASK;
    end
    else if (busy)
      busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
  end

  // reset stands in for a power cycle: stored settings come back at their defaults
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      nv_reg <= NFS_SR_NV_RESET; // [RL4] [RL5]
    else if (finish && op_reg == NFS_OP_WRSR)
      nv_reg <= pend_nv_reg; // [RL15] [RL1]
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      array_op_start <= 1'b0;
      array_op       <= NFS_OP_NONE;
      array_addr     <= '0;
    end
    else
    begin
      array_op_start <= start & (req_op != NFS_OP_WRSR);
      if (start)
      begin
        array_op   <= req_op;
        array_addr <= addr_reg[NFS_ADDR_W-1:0] & NFS_ADDR_LAST; // [RL12]
      end
    end
  end

  assign status_byte = {nv_reg[7:2], wel_reg, busy}; // [RL9]
  assign flag_byte   = {~busy, 6'h00, 1'b1}; // [RL13] [RL11]

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_busy_inverse: assert property (status_byte[0] == ~flag_byte[7]) // [RL11]
    else $error("status busy bit not inverse of flag ready bit");
  a_busy_onset: assert property (start |=> status_byte[0] && !flag_byte[7]) // [RL9] [RL13]
    else $error("busy not shown after operation start");
  a_wel_reset: assert property (!$past(rst_b) |-> !wel_reg) // [RL8]
    else $error("write enable latch set after reset");
  a_freeze_wrsr: assert property ((exec && req_op == NFS_OP_WRSR && frozen) |=> !busy) // [RL2]
    else $error("status write ran while frozen");
  a_wel_gate: assert property (start |-> $past(wel_reg, 1) || wel_reg) // [RL7]
    else $error("operation started without write enable");
  a_region_guard: assert property ((start && req_op != NFS_OP_WRSR) |-> !blocked) // [RL6]
    else $error("operation started in protected region");
  a_die_gate: assert property ((start && req_op == NFS_OP_DIE) |-> bp == 4'h0) // [RL10]
    else $error("die erase started with protection bits set");
  a_nv_hold: assert property ( // [RL15]
    (busy && op_reg == NFS_OP_WRSR && !finish) |=> $stable(nv_reg))
    else $error("nonvolatile bits changed mid write cycle");
  a_wel_autoclr: assert property ((finish || reject) |=> !wel_reg) // [RL14]
    else $error("write enable latch not cleared after operation");
  a_wrsr_apply: assert property ( // [RL1]
    (finish && op_reg == NFS_OP_WRSR) |=> nv_reg == $past(pend_nv_reg))
    else $error("status write value not applied");

  c_wrsr_done: cover property (finish && op_reg == NFS_OP_WRSR);
  c_frozen_try: cover property (exec && req_op == NFS_OP_WRSR && frozen);
  c_guard_reject: cover property (reject && blocked);
  c_die_start: cover property (start && req_op == NFS_OP_DIE);

endmodule : nfs_status_protect

/* File: rtl/nfs_pkg.sv */
package nfs_pkg;

  // command opcodes (4-byte address forms for array commands)
  localparam logic [7:0] NFS_CMD_WREN  = 8'h06;
  localparam logic [7:0] NFS_CMD_WRDI  = 8'h04;
  localparam logic [7:0] NFS_CMD_RDSR  = 8'h05;
  localparam logic [7:0] NFS_CMD_WRSR  = 8'h01;
  localparam logic [7:0] NFS_CMD_RDFS  = 8'h70;
  localparam logic [7:0] NFS_CMD_PROG  = 8'h12;
  localparam logic [7:0] NFS_CMD_SE    = 8'hDC;
  localparam logic [7:0] NFS_CMD_SS32  = 8'h5C;
  localparam logic [7:0] NFS_CMD_SS4   = 8'h21;
  localparam logic [7:0] NFS_CMD_DIE   = 8'hC4;

  // status byte layout
  localparam int unsigned NFS_SR_SRWD_BIT = 7;
  localparam int unsigned NFS_SR_BP3_BIT  = 6;
  localparam int unsigned NFS_SR_TB_BIT   = 5;
  localparam int unsigned NFS_SR_BP_LO    = 2;
  localparam int unsigned NFS_SR_BP_HI    = 4;
  localparam int unsigned NFS_SR_WEL_BIT  = 1;
  localparam int unsigned NFS_SR_WIP_BIT  = 0;
  localparam logic [7:0]  NFS_SR_NV_MASK  = 8'hFC;
  localparam logic [7:0]  NFS_SR_NV_RESET = 8'h00;

  // flag status byte layout
  localparam int unsigned NFS_FS_READY_BIT = 7;
  localparam int unsigned NFS_FS_ADDR4_BIT = 0;

  // memory map
  localparam int unsigned NFS_ADDR_W       = 27;
  localparam logic [26:0] NFS_ADDR_LAST    = 27'h7FF_FFFF;
  localparam int unsigned NFS_SECTOR_SHIFT = 16;
  localparam int unsigned NFS_SECTOR_W     = 11;
  localparam logic [11:0] NFS_SECTOR_COUNT = 12'h800;
  localparam logic [3:0]  NFS_BP_ALL       = 4'hC;

  // frame bit counts (last bit index of each phase)
  localparam logic [5:0] NFS_LAST_BYTE_BIT = 6'h07;
  localparam logic [5:0] NFS_LAST_ADDR_BIT = 6'h1F;

  // default busy times in core clock cycles
  localparam logic [31:0] NFS_T_WRSR_CYC  = 32'h0000_0100;
  localparam logic [31:0] NFS_T_PROG_CYC  = 32'h0000_0400;
  localparam logic [31:0] NFS_T_SUB_CYC   = 32'h0000_2000;
  localparam logic [31:0] NFS_T_SECT_CYC  = 32'h0000_8000;
  localparam logic [31:0] NFS_T_DIE_CYC   = 32'h0002_0000;

  typedef enum logic [2:0]
  {
    NFS_ST_IDLE = 3'b000,
    NFS_ST_CMD  = 3'b001,
    NFS_ST_ADDR = 3'b010,
    NFS_ST_DATA = 3'b011,
    NFS_ST_READ = 3'b100,
    NFS_ST_SKIP = 3'b101
  } nfs_state_e;

  typedef enum logic [2:0]
  {
    NFS_OP_NONE = 3'b000,
    NFS_OP_WRSR = 3'b001,
    NFS_OP_PROG = 3'b010,
    NFS_OP_SE   = 3'b011,
    NFS_OP_SS32 = 3'b100,
    NFS_OP_SS4  = 3'b101,
    NFS_OP_DIE  = 3'b110
  } nfs_op_e;

endpackage : nfs_pkg

/* File: rtl/nfs_sync.sv */
`timescale 1ns/100ps
module nfs_sync
#(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // reset level should be each pin's idle level, else a false edge follows reset
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule : nfs_sync

/* File: rtl/nfs_region_guard.sv */
`timescale 1ns/100ps
module nfs_region_guard
  import nfs_pkg::*;
(
  // protection settings
  input  wire logic [3:0]              bp,
  input  wire logic                    top_bottom,
  // target of the operation
  input  wire logic [NFS_SECTOR_W-1:0] sector,
  input  wire logic                    die,
  // verdict
  output logic                         blocked
);

  logic [11:0] span;
  logic [11:0] sect_ext;

  always_comb
  begin
    span     = 12'h001 << (bp - 4'h1);
    sect_ext = {1'b0, sector};
    if (die)
      blocked = (bp != 4'h0); // [RL10]
    else if (bp == 4'h0)
      blocked = 1'b0;
    else if (bp >= NFS_BP_ALL)
      blocked = 1'b1; // [RL6]
    else if (top_bottom)
      blocked = (sect_ext < span); // [RL6]
    else
      blocked = (sect_ext >= (NFS_SECTOR_COUNT - span)); // [RL6]
  end

endmodule : nfs_region_guard

/* File: tb/nfs_host_model.sv */
`timescale 1ns/100ps
module nfs_host_model
(
  // pacing clock
  input  wire logic       clock,
  // link pins
  output logic            link_clk,
  output logic            link_sel_b,
  output logic            link_din,
  input  wire logic       link_dout,
  // captured read byte
  output logic            rd_valid,
  output logic [7:0]      rd_byte
);
  initial
  begin
    link_clk   = 1'b0;
    link_sel_b = 1'b1;
    link_din   = 1'b0;
    rd_valid   = 1'b0;
    rd_byte    = 8'h00;
  end

  // mode 0: clock rests low outside frames, 8 core cycles per half period (80 ns)
  task automatic frame(input logic [39:0] d, input int nb, input bit cap);
    int         i;
    logic [7:0] sh;
    sh = 8'h00;
    @(posedge clock);
    link_sel_b <= 1'b0;
    for (i = 8 * nb - 1; i >= 0; i--)
    begin
      link_din <= d[i];
      repeat (8) @(posedge clock);
      link_clk <= 1'b1;
      repeat (8) @(posedge clock);
      // sampled late in the high phase: the output moves only after the falling edge
      sh = {sh[6:0], link_dout};
      link_clk <= 1'b0;
    end
    repeat (8) @(posedge clock);
    link_sel_b <= 1'b1;
    link_din   <= ~link_din;
    rd_byte    <= sh;
    rd_valid   <= cap;
    @(posedge clock);
    rd_valid <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : frame
endmodule : nfs_host_model

/* File: tb/nfs_status_protect_tb.sv */
`timescale 1ns/100ps
module nfs_status_protect_tb
  import nfs_pkg::*;
;
  logic                  clock;
  logic                  rst_b;
  logic                  wp_b;
  logic                  link_clk;
  logic                  link_sel_b;
  logic                  link_din;
  logic                  link_dout;
  logic                  link_dout_oe;
  logic                  array_op_start;
  logic [2:0]            array_op;
  logic [NFS_ADDR_W-1:0] array_addr;
  logic [7:0]            status_byte;
  logic [7:0]            flag_byte;
  logic                  busy;
  logic                  rd_valid;
  logic [7:0]            rd_byte;
  logic [7:0]            rd_q[$];
  logic [30:0]           op_q[$];
  logic [7:0]            erase_cmd[3];
  logic [2:0]            erase_code[3];
  logic [15:0]           a;
  localparam logic [31:0] T_OP_CYC = 32'h0000_0320;
  logic [31:0]           busy_len;
  int                    error_cnt;
  int                    checks;
  int                    seed;
  int                    k;

  initial clock = 1'b0;
  always #5 clock = ~clock;

  nfs_status_protect #(
    .T_WRSR_CYC(T_OP_CYC),
    .T_PROG_CYC(T_OP_CYC),
    .T_SUB_CYC (T_OP_CYC),
    .T_SECT_CYC(T_OP_CYC),
    .T_DIE_CYC (T_OP_CYC)
  ) u_nfs_status_protect (
    .clock(clock), .rst_b(rst_b), .link_clk(link_clk), .link_sel_b(link_sel_b),
    .link_din(link_din), .link_dout(link_dout), .link_dout_oe(link_dout_oe), .wp_b(wp_b),
    .array_op_start(array_op_start), .array_op(array_op), .array_addr(array_addr),
    .status_byte(status_byte), .flag_byte(flag_byte), .busy(busy)
  );

  nfs_host_model u_nfs_host_model (
    .clock(clock), .link_clk(link_clk), .link_sel_b(link_sel_b), .link_din(link_din),
    .link_dout(link_dout), .rd_valid(rd_valid), .rd_byte(rd_byte)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // notes are taken off in order by the watcher below
  always @(negedge clock)
  begin
    if (rd_valid === 1'b1)
    begin
      check("read drive", {31'h0, link_dout_oe}, 32'h1);
      if (rd_q.size() == 0)
        check("read note", 32'h1, 32'h0);
      else
        check("read byte", {24'h0, rd_byte}, {24'h0, rd_q.pop_front()});
    end
    // every cycle in this bench lasts T_OP_CYC core cycles
    if (busy === 1'b1)
      busy_len = busy_len + 32'h1;
    else if (busy_len != 32'h0)
    begin
      check("busy length", busy_len, T_OP_CYC);
      check("ready flags", {24'h0, flag_byte}, 32'h0000_0081);
      check("ready status", {31'h0, status_byte[0]}, 32'h0);
      busy_len = 32'h0;
    end
    if (busy_len == 32'h1)
      check("busy flags", {24'h0, flag_byte}, 32'h0000_0001);
    if (array_op_start === 1'b1)
    begin
      if (op_q.size() == 0)
        check("unexpected op", {29'h0, array_op}, 32'h0);
      else
      begin
        check("array op", {29'h0, array_op}, {29'h0, op_q[0][29:27]});
        if (op_q[0][30])
          check("array addr", {5'h0, array_addr}, {5'h0, op_q[0][26:0]});
        void'(op_q.pop_front());
      end
    end
  end

  task automatic cmd(input logic [7:0] c);
    u_nfs_host_model.frame({32'h0, c}, 1, 1'b0);
  endtask : cmd

  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    rd_q.push_back(e);
    u_nfs_host_model.frame({24'h0, c, 8'h00}, 2, 1'b1);
  endtask : rd

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000)
    begin
      check("busy timeout", 32'h1, 32'h0);
      complete_run();
    end
  endtask : wait_idle

  task automatic wrsr(input logic [7:0] v);
    cmd(NFS_CMD_WREN);
    u_nfs_host_model.frame({24'h0, NFS_CMD_WRSR, v}, 2, 1'b0);
  endtask : wrsr

  task automatic op(input logic [7:0] c, input logic [26:0] ad, input bit ok,
                    input logic [2:0] code, input bit chk);
    logic [4:0] hi;
    hi = 5'($random(seed));
    cmd(NFS_CMD_WREN);
    if (ok)
      op_q.push_back({chk, code, ad});
    if (c == NFS_CMD_DIE)
      u_nfs_host_model.frame({32'h0, c}, 1, 1'b0);
    else
      u_nfs_host_model.frame({c, hi, ad}, 5, 1'b0);
    wait_idle();
  endtask : op

  initial
  begin
    seed = 25047;
    busy_len = 32'h0;
    error_cnt = 0;
    checks = 0;
    erase_cmd = '{NFS_CMD_SE, NFS_CMD_SS32, NFS_CMD_SS4};
    erase_code = '{3'h3, 3'h4, 3'h5};
    wp_b = 1'b1;
    rst_b = 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd(NFS_CMD_RDSR, 8'h00);
    rd(NFS_CMD_RDFS, 8'h81);
    cmd(NFS_CMD_WREN);
    rd(NFS_CMD_RDSR, 8'h02);
    cmd(NFS_CMD_WRDI);
    rd(NFS_CMD_RDSR, 8'h00);
    // program with the latch clear must not start
    u_nfs_host_model.frame({NFS_CMD_PROG, 5'h00, 27'h000_1234}, 5, 1'b0);
    wrsr(8'hA7);
    rd(NFS_CMD_RDSR, 8'h03);
    rd(NFS_CMD_RDFS, 8'h01);
    wait_idle();
    rd(NFS_CMD_RDSR, 8'hA4);
    @(posedge clock);
    wp_b <= 1'b0;
    wrsr(8'h00);
    wait_idle();
    rd(NFS_CMD_RDSR, 8'hA4);
    a = 16'($random(seed));
    op(NFS_CMD_SE, {11'h000, a}, 1'b0, 3'h3, 1'b1);
    op(NFS_CMD_DIE, 27'h0, 1'b0, 3'h6, 1'b0);
    rd(NFS_CMD_RDSR, 8'hA4);
    op(NFS_CMD_PROG, {11'h005, a}, 1'b1, 3'h2, 1'b1);
    @(posedge clock);
    wp_b <= 1'b1;
    wrsr(8'h04);
    wait_idle();
    rd(NFS_CMD_RDSR, 8'h04);
    for (k = 0; k < 3; k++)
    begin
      a = 16'($random(seed));
      op(erase_cmd[k], {11'h7FF, a}, 1'b0, erase_code[k], 1'b1);
      op(erase_cmd[k], {11'h7FE, a}, 1'b1, erase_code[k], 1'b1);
    end
    wrsr(8'h00);
    wait_idle();
    op(NFS_CMD_DIE, 27'h0, 1'b1, 3'h6, 1'b0);
    repeat (20) @(posedge clock);
    check("pending notes", rd_q.size() + op_q.size(), 32'h0);
    complete_run();
  end
endmodule : nfs_status_protect_tb
